// ### verilog/smpor_pkg.sv
// Package of constants and types for the supply monitor power-on reset block.
package smpor_pkg;

  // Minimum reset period in nanoseconds; the figure is a plain default, no value is given for it.
  localparam int unsigned MIN_RESET_PERIOD_NS = 1000;

  // Clock period of the core clock in nanoseconds (250 MHz).
  localparam int unsigned CORE_CLK_PERIOD_NS  = 4;

  // Cycles in the minimum reset period, rounded up, never below one.
  localparam int unsigned MIN_RESET_CYCLES    =
    ((MIN_RESET_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS) < 1 ? 1 :
    ((MIN_RESET_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS);

  // Width of the reset period counter.
  localparam int unsigned TIMER_W             = 12;

  // Reset value of the counter.
  localparam logic [TIMER_W-1:0] TIMER_RESET  = 12'h000;

  // Last count of the reset period.
  localparam logic [TIMER_W-1:0] TIMER_LAST   = TIMER_W'(MIN_RESET_CYCLES - 1);

  // Width of the control register bank that the reset guards.
  localparam int unsigned REG_W               = 8;

  // Number of registers in the guarded bank.
  localparam int unsigned REG_N               = 4;

  // Width of the register address on the write port.
  localparam int unsigned ADDR_W              = 2;

  // Index of the register that holds the PLL-domain settings.
  localparam logic [ADDR_W-1:0] PLL_REG_IDX   = 2'h3;

  // Default value of every register in the bank.
  localparam logic [REG_W-1:0] REG_DEFAULT    = 8'h00;

  // States of the main reset sequencer.
  typedef enum logic [1:0] {
    SMPOR_UNPOWERED,
    SMPOR_HOLD,
    SMPOR_RUN
  } smpor_state_t;

endpackage

// ### verilog/smpor_top.sv
// Power-on reset sequencer with supply monitors, guarded register bank and PLL-domain reset.
`timescale 1ns/1ps

module smpor_top (
  input  wire logic                          i_core_clk,          // Core clock, 250 MHz.
  input  wire logic                          i_srst,              // Synchronous reset, active high.
  input  wire logic                          i_analog_on_ok,      // Analog supply above on-threshold.
  input  wire logic                          i_analog_off_ok,     // Analog supply above off-threshold.
  input  wire logic                          i_core_on_ok,        // Core supply above on-threshold.
  input  wire logic                          i_core_off_ok,       // Core supply above off-threshold.
  input  wire logic                          i_pll_supply_ok,     // PLL supply above its threshold.
  input  wire logic                          i_wr_en,             // Control-interface write strobe.
  input  wire logic [smpor_pkg::ADDR_W-1:0]  i_wr_addr,           // Control-interface write address.
  input  wire logic [smpor_pkg::REG_W-1:0]   i_wr_data,           // Control-interface write data.
  input  wire logic [smpor_pkg::ADDR_W-1:0]  i_rd_addr,           // Read-back address.
  output logic                               o_por_n,             // Internal reset, active low.
  output logic                               o_pll_rst_n,         // PLL-domain reset, active low.
  output logic                               o_pll_enable,        // PLLs, oscillator and clock output allowed.
  output logic                               o_full_function,     // All supplies good, full function.
  output logic                               o_wr_dropped,        // Pulse: a write was discarded while the main reset was low.
  output logic [smpor_pkg::REG_W-1:0]        o_rd_data            // Registered read-back data.
);
  import smpor_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor input synchronisers.
  ////////////////////////////////////////////////////////////////////////////////

  // Three-stage shift for each of the five monitor flags; stage 1 feeds only stage 2.
  logic [4:0] mon_raw;                     // Raw monitor flags, packed.
  logic [4:0] sync1_q, sync2_q, sync3_q;   // Synchroniser stages.
  logic [4:0] sync1_d, sync2_d, sync3_d;   // Next stage values.
  logic [4:0] mon_q, mon_d;                // Filtered monitor levels.

  assign mon_raw = {i_pll_supply_ok, i_core_off_ok, i_core_on_ok, i_analog_off_ok, i_analog_on_ok};

  // Shift the stages; a level counts only when stages two and three agree, which
  // rejects a single sampled glitch at the cost of one more cycle of delay.
  always_comb begin
    sync1_d = mon_raw;
    sync2_d = sync1_q;
    sync3_d = sync2_q;
    mon_d   = mon_q;
    for (int i = 0; i < 5; i++) begin
      if (sync2_q[i] == sync3_q[i]) begin
        mon_d[i] = sync3_q[i];
      end
    end
  end

  // Register the synchroniser; monitors read as low after reset so reset is held.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      sync3_q <= 5'h00;
      mon_q   <= 5'h00;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
      mon_q   <= mon_d;
    end
  end

  // Named views of the filtered levels.
  logic a_on, a_off, c_on, c_off, p_ok;
  assign a_on  = mon_q[0];
  assign a_off = mon_q[1];
  assign c_on  = mon_q[2];
  assign c_off = mon_q[3];
  assign p_ok  = mon_q[4];

  // Term shared by the sequencer and the assertions: either supply below its off-threshold.
  logic supply_lost;
  assign supply_lost = !a_off || !c_off;

  ////////////////////////////////////////////////////////////////////////////////
  // Main reset sequencer.
  ////////////////////////////////////////////////////////////////////////////////

  smpor_state_t          state_q, state_d;  // Sequencer state.
  logic [TIMER_W-1:0]    timer_q, timer_d;  // Reset period counter.
  logic                  por_n_q, por_n_d;  // Registered reset output.

  // Hold reset until both on-thresholds are met and the minimum period has run;
  // drop back to hold the moment a supply falls below its off-threshold.
  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    por_n_d = 1'b0;
    case (state_q)
      SMPOR_UNPOWERED: begin
        // Output is only trusted once the analog supply is up.
        if (a_on) begin
          state_d = SMPOR_HOLD;
          timer_d = TIMER_RESET;
        end
      end
      SMPOR_HOLD: begin
        if (supply_lost || !a_on || !c_on) begin
          timer_d = TIMER_RESET;
        end else if (timer_q == TIMER_LAST) begin
          state_d = SMPOR_RUN;
          por_n_d = 1'b1;
        end else begin
          timer_d = timer_q + TIMER_W'(1);
        end
      end
      SMPOR_RUN: begin
        // A brown-out above the off-thresholds is ignored here.
        if (supply_lost) begin
          state_d = SMPOR_HOLD;
          timer_d = TIMER_RESET;
        end else begin
          por_n_d = 1'b1;
        end
      end
      default: begin
        state_d = SMPOR_UNPOWERED;
      end
    endcase
  end

  // Register the sequencer; release is clocked so it is glitch-free.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_q <= SMPOR_UNPOWERED;
      timer_q <= TIMER_RESET;
      por_n_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      por_n_q <= por_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // PLL-domain reset.
  ////////////////////////////////////////////////////////////////////////////////

  logic pll_rst_n_q, pll_rst_n_d;  // PLL-domain reset, active low.
  logic full_q, full_d;            // Full function indication.

  // The PLL domain needs its own supply and the main reset released.
  always_comb begin
    pll_rst_n_d = p_ok && por_n_d;
    full_d      = por_n_d && p_ok;
  end

  // Register the PLL-domain outputs; a grounded PLL supply keeps them low.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pll_rst_n_q <= 1'b0;
      full_q      <= 1'b0;
    end else begin
      pll_rst_n_q <= pll_rst_n_d;
      full_q      <= full_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Guarded register bank.
  ////////////////////////////////////////////////////////////////////////////////

  logic [REG_W-1:0] regs_q [REG_N];   // Register bank.
  logic [REG_W-1:0] regs_d [REG_N];   // Next register values.
  logic             drop_q, drop_d;   // Discarded write pulse.
  logic [REG_W-1:0] rd_q, rd_d;       // Read-back data.

  // Writes land only while reset is released; reset returns every register to
  // default, and the PLL register is also held at default while its domain is in reset.
  always_comb begin
    drop_d = i_wr_en && !por_n_q;
    rd_d   = regs_q[i_rd_addr];
    for (int i = 0; i < REG_N; i++) begin
      regs_d[i] = regs_q[i];
      if (!por_n_q) begin
        regs_d[i] = REG_DEFAULT;
      end else if (i_wr_en && i_wr_addr == ADDR_W'(i)) begin
        regs_d[i] = i_wr_data;
      end
    end
    if (!pll_rst_n_q) begin
      regs_d[PLL_REG_IDX] = REG_DEFAULT;
    end
  end

  // Register the bank and the read-back.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      for (int i = 0; i < REG_N; i++) begin
        regs_q[i] <= REG_DEFAULT;
      end
      drop_q <= 1'b0;
      rd_q   <= REG_DEFAULT;
    end else begin
      for (int i = 0; i < REG_N; i++) begin
        regs_q[i] <= regs_d[i];
      end
      drop_q <= drop_d;
      rd_q   <= rd_d;
    end
  end

  // Outputs straight from flip-flops.
  assign o_por_n         = por_n_q;
  assign o_pll_rst_n     = pll_rst_n_q;
  assign o_pll_enable    = pll_rst_n_q;
  assign o_full_function = full_q;
  assign o_wr_dropped    = drop_q;
  assign o_rd_data       = rd_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  ////////////////////////////////////////////////////////////////////////////////

  // Cycles the reset output has stayed low, saturating at the last period count.
  // Counting apart from the sequencer keeps the period check independent of its timer,
  // so a timer that skipped counts is caught here, unless the reset output had already been low for the full period before the timer started.
  logic [TIMER_W-1:0] low_cnt_q, low_cnt_d;  // Low-time counter for the period check.

  // Count while the reset output is low, clear it on release.
  always_comb begin
    low_cnt_d = low_cnt_q;
    if (por_n_q) begin
      low_cnt_d = TIMER_RESET;
    end else if (low_cnt_q != TIMER_LAST) begin
      low_cnt_d = low_cnt_q + TIMER_W'(1);
    end
  end

  // Register the low-time counter.
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      low_cnt_q <= TIMER_RESET;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end

  chk_lost_asserts: assert property (@(posedge i_core_clk) disable iff (i_srst)
    supply_lost |=> !o_por_n)
    else $error("Reset not asserted after supply loss.");

  chk_release_needs: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $rose(o_por_n) |-> $past(a_on) && $past(c_on))
    else $error("Reset released without both supplies on.");

  chk_min_period: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $rose(o_por_n) |-> $past(timer_q) == TIMER_LAST)
    else $error("Reset released before minimum period.");

  chk_drop_write: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_wr_en && !o_por_n) |=> o_wr_dropped && regs_q[$past(i_wr_addr)] == REG_DEFAULT)
    else $error("Write during reset was not discarded.");

  chk_write_lands: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_wr_en && o_por_n && o_pll_rst_n && !supply_lost) |=> regs_q[$past(i_wr_addr)] == $past(i_wr_data))
    else $error("Write after release did not land.");

  chk_pll_off: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !p_ok |=> !o_pll_rst_n && !o_pll_enable)
    else $error("PLL domain not held in reset.");

  chk_full_func: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_full_function |-> o_por_n && o_pll_rst_n && $past(p_ok) && $past(a_off) && $past(c_off))
    else $error("Full function without all supplies.");

  chk_unpowered_low: assert property (@(posedge i_core_clk) disable iff (i_srst)
    state_q == SMPOR_UNPOWERED |-> !o_por_n ##0 !o_full_function)
    else $error("Reset released before analog supply up.");

  chk_min_low_time: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $rose(o_por_n) |-> $past(low_cnt_q) == TIMER_LAST)
    else $error("Reset low for less than the minimum period.");

  chk_low_stays_low: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (!o_por_n && (!a_on || !c_on)) |=> !o_por_n)
    else $error("Reset released while a supply was below its on-threshold.");

  chk_brownout_keeps: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (o_por_n && !supply_lost) |=> o_por_n)
    else $error("Reset asserted during a brown-out above the off-thresholds.");

  chk_full_needs_pll: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !p_ok |=> !o_full_function)
    else $error("Full function shown without the PLL supply.");

  chk_pll_reg_default: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !o_pll_rst_n |=> regs_q[PLL_REG_IDX] == REG_DEFAULT)
    else $error("PLL register changed while its domain was in reset.");

endmodule

// ### tb/smpor_host.sv
// Host model that writes the control interface of the power-on reset block.
`timescale 1ns/1ps
module smpor_host (
  input  wire logic                    i_core_clk, // Core clock.
  input  wire logic                    i_por_n,    // Internal reset as the host sees it.
  output logic                         o_wr_en,    // Write strobe.
  output logic [smpor_pkg::ADDR_W-1:0] o_wr_addr,  // Write index.
  output logic [smpor_pkg::REG_W-1:0]  o_wr_data   // Write data.
);
  import smpor_pkg::*;
  // Idle bus at time zero.
  initial begin
    o_wr_en = 1'b0;
    o_wr_addr = '0;
    o_wr_data = '0;
  end
  // One write pulse; early lets the bench bypass the host's own reset check on purpose.
  task automatic write(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d, input logic early,
                       output logic took);
    took = early || (i_por_n === 1'b1);
    if (took) begin
      @(negedge i_core_clk);
      o_wr_en = 1'b1;
      o_wr_addr = a;
      o_wr_data = d;
      @(negedge i_core_clk);
      o_wr_en = 1'b0;
      // Released lines show the inverse, so a stale value cannot pass for fresh data.
      o_wr_addr = ~a;
      o_wr_data = ~d;
    end
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench of the supply monitor power-on reset block.
`timescale 1ns/1ps
module tb_top;
  import smpor_pkg::*;
  logic              clk, srst, a_on, a_off, c_on, c_off, p_ok;  // Clock, reset and monitor flags.
  logic              wr_en, por_n, pll_rst_n, pll_en, full_fn, dropped, took;
  logic [ADDR_W-1:0] wr_addr, rd_addr;                           // Write and read indices.
  logic [REG_W-1:0]  wr_data, rd_data;                           // Write and read data.
  logic [REG_W-1:0]  bank [REG_N];                               // Expected register contents.
  logic [15:0]       lfsr;                                       // Random source.
  int                fails, check_count, n;

  // Core clock, 4 ns period.
  initial clk = 1'b0;
  always #2 clk = ~clk;

  smpor_top DUT (.i_core_clk(clk), .i_srst(srst), .i_analog_on_ok(a_on), .i_analog_off_ok(a_off),
    .i_core_on_ok(c_on), .i_core_off_ok(c_off), .i_pll_supply_ok(p_ok), .i_wr_en(wr_en),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_addr(rd_addr), .o_por_n(por_n),
    .o_pll_rst_n(pll_rst_n), .o_pll_enable(pll_en), .o_full_function(full_fn),
    .o_wr_dropped(dropped), .o_rd_data(rd_data));
  smpor_host u_host (.i_core_clk(clk), .i_por_n(por_n), .o_wr_en(wr_en), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data));

  // Next state of the sixteen-bit shift register.
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Counts and verdict.
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compare with case equality so an unknown never matches.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Read back one register a cycle after the index is set.
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    chk(rd_data, e, "read back");
  endtask

  // Wait, bounded, for the internal reset to reach a level; a hang ends the run.
  task automatic wait_por(input logic lvl, input int bound, output int cyc);
    cyc = 0;
    while (por_n !== lvl && cyc < bound) begin
      @(negedge clk);
      cyc++;
    end
    if (por_n !== lvl) begin
      fails++;
      $display("[ERR] %0t reset level not reached", $time);
      test_done();
    end
  endtask

  initial begin
    {srst, a_on, a_off, c_on, c_off, p_ok} = 6'h20;
    rd_addr = '0;
    lfsr = 16'h0f4d;  // Seed 3917.
    fails = 0;
    check_count = 0;
    for (int i = 0; i < REG_N; i++) bank[i] = REG_DEFAULT;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    repeat (20) @(negedge clk);
    chk(8'(por_n), 8'h00, "supplies low");
    u_host.write(2'h1, 8'h5a, 1'b1, took);
    chk(8'(dropped), 8'h01, "early write");
    {a_on, a_off} = 2'b11;
    repeat (MIN_RESET_CYCLES + 20) @(negedge clk);
    chk(8'(por_n), 8'h00, "analog only");
    {c_on, c_off} = 2'b11;
    wait_por(1'b1, MIN_RESET_CYCLES + 20, n);
    chk(8'(n >= MIN_RESET_CYCLES), 8'h01, "reset period");
    for (int i = 0; i < REG_N; i++) rd(ADDR_W'(i), REG_DEFAULT);
    chk(8'({pll_rst_n, pll_en, full_fn}), 8'h00, "pll off");
    u_host.write(PLL_REG_IDX, 8'ha5, 1'b0, took);
    chk(8'(took), 8'h01, "host wrote");
    rd(PLL_REG_IDX, REG_DEFAULT);
    p_ok = 1'b1;
    repeat (10) @(negedge clk);
    chk(8'({pll_rst_n, pll_en, full_fn}), 8'h07, "all good");
    for (int k = 0; k < 12; k++) begin
      u_host.write(lfsr[1:0], lfsr[15:8], 1'b0, took);
      chk(8'(dropped), 8'h00, "write taken");
      bank[lfsr[1:0]] = lfsr[15:8];
      lfsr = nxt(lfsr);
    end
    for (int i = 0; i < REG_N; i++) rd(ADDR_W'(i), bank[i]);
    {a_on, c_on} = 2'b00;
    repeat (30) @(negedge clk);
    chk(8'(por_n), 8'h01, "brown-out");
    {a_on, c_on} = 2'b11;
    for (int i = 0; i < REG_N; i++) rd(ADDR_W'(i), bank[i]);
    {c_on, c_off} = 2'b00;
    wait_por(1'b0, 8, n);
    u_host.write(2'h0, 8'hff, 1'b1, took);
    chk(8'(dropped), 8'h01, "write in reset");
    {c_on, c_off} = 2'b11;
    wait_por(1'b1, MIN_RESET_CYCLES + 20, n);
    for (int i = 0; i < REG_N; i++) rd(ADDR_W'(i), REG_DEFAULT);
    p_ok = 1'b0;
    repeat (10) @(negedge clk);
    chk(8'({pll_rst_n, pll_en, full_fn, por_n}), 8'h01, "pll lost");
    {a_on, a_off} = 2'b00;
    wait_por(1'b0, 8, n);
    srst = 1'b1;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    chk(8'({por_n, pll_rst_n, full_fn, dropped}), 8'h00, "after reset");
    {a_on, a_off, c_on, c_off, p_ok} = 5'h1f;
    wait_por(1'b1, MIN_RESET_CYCLES + 20, n);
    chk(8'(n >= MIN_RESET_CYCLES), 8'h01, "zero rise");
    chk(8'({pll_rst_n, pll_en, full_fn}), 8'h07, "all up at once");
    test_done();
  end
endmodule
